// >>> hdl/gauge_scan_map.svh
`ifndef GAUGE_SCAN_MAP_SVH
`define GAUGE_SCAN_MAP_SVH

// ----------------------------------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------------------------------
`define MAG_BASE_IDX 6'h00
`define DIR_BASE_IDX 6'h0C
`define SCAN_STATUS_CONTROL_IDX 6'h12

// ----------------------------------------------------------------
// scan_status_control fields
// ----------------------------------------------------------------
`define SCAN_STATUS_CONTROL_IRQ_EN_BIT 7
`define SCAN_STATUS_CONTROL_FLAG_BIT 6
`define SCAN_STATUS_CONTROL_FLAG_CLR_BIT 5
`define SCAN_STATUS_CONTROL_CLK_SEL_HI_BIT 4
`define SCAN_STATUS_CONTROL_CLK_SEL_LO_BIT 3
`define SCAN_STATUS_CONTROL_START_BIT 1
`define SCAN_STATUS_CONTROL_AUTO_BIT 0

// ----------------------------------------------------------------
// direction register fields
// ----------------------------------------------------------------
`define DIR_COIL1_BIT 0
`define DIR_COIL2_BIT 1
`define DIR_MINOR_BIT 0

// ----------------------------------------------------------------
// geometry, reset values, timing
// ----------------------------------------------------------------
`define COIL_COUNT 12
`define GAUGE_COUNT 6
`define MAJOR_COUNT 2
`define SYNC_COIL_IDX 4'hA
`define LAST_COIL_IDX 4'hB
`define MAG_RESET 8'h00
`define DIR_RESET 2'h0
`define DIV_BASE_CYC 512
`define DAC_WAIT_CYC 16

`endif

// >>> hdl/gauge_scan_pkg.sv
package gauge_scan_pkg;

    typedef enum logic {
        SEQ_IDLE,
        SEQ_SCAN
    } seq_state_t;

    typedef logic [3:0] coil_idx_t;
    typedef logic [2:0] gauge_idx_t;
    typedef logic [7:0] mag_t;
    typedef logic [1:0] dir_pair_t;

endpackage

// >>> hdl/coil_step_timer.sv
`include "gauge_scan_map.svh"

module coil_step_timer
    import gauge_scan_pkg::*;
#(
    parameter int DIV_BASE = `DIV_BASE_CYC,
    parameter int DAC_WAIT = `DAC_WAIT_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic [1:0] clk_sel_in,
    output logic step_start_out,
    output logic dac_load_out,
    output logic hold_close_out,
    output logic step_end_out
);

    logic [12:0] cnt;
    wire [12:0] base = 13'(DIV_BASE);
    wire [12:0] wait_at = 13'(DAC_WAIT);
    // interval is the bus clock divided by 512, 1024, 2048 or 4096
    wire [12:0] limit = (base << clk_sel_in) - 13'h0001;

    assign step_start_out = run_in && (cnt == 13'h0000);
    assign dac_load_out = run_in && (cnt == 13'h0001);
    assign hold_close_out = run_in && (cnt == wait_at);
    assign step_end_out = run_in && (cnt == limit);

    // the count restarts at zero whenever the sequencer parks
    always_ff @(posedge clk_in) begin
        if (rst_in || !run_in || step_end_out) begin
            cnt <= 13'h0000;
        end else begin
            cnt <= cnt + 13'h0001;
        end
    end

endmodule // coil_step_timer

// >>> hdl/gauge_coil_scan_sequencer.sv
`include "gauge_scan_map.svh"

module gauge_coil_scan_sequencer
    import gauge_scan_pkg::*;
#(
    parameter int DIV_BASE = `DIV_BASE_CYC,
    parameter int DAC_WAIT = `DAC_WAIT_CYC
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    input wire logic [5:0] GAUGE_ENABLE_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    output logic [7:0] DAC_DATA_OUT,
    output logic [3:0] COIL_SEL_OUT,
    output logic [11:0] HOLD_SWITCH_OUT,
    output logic [11:0] COIL_DIR_OUT,
    output logic [5:0] DRIVE_ON_OUT,
    output logic IRQ_OUT
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic dir_of_coil(input dir_pair_t pair, input coil_idx_t c);
        // minor coil 1 is a half bridge and has no polarity of its own
        if (c[0]) begin
            dir_of_coil = pair[`DIR_COIL2_BIT];
        end else if (c[3:1] < 3'(`MAJOR_COUNT)) begin
            dir_of_coil = pair[`DIR_COIL1_BIT];
        end else begin
            dir_of_coil = 1'b0;
        end
    endfunction

    function automatic logic [7:0] dir_read(input dir_pair_t pair, input gauge_idx_t g);
        if (g < 3'(`MAJOR_COUNT)) begin
            dir_read = {6'h00, pair};
        end else begin
            dir_read = {7'h00, pair[`DIR_COIL2_BIT]};
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    mag_t mag_mst [`COIL_COUNT];
    mag_t mag_slv [`COIL_COUNT];
    dir_pair_t dir_mst [`GAUGE_COUNT];
    dir_pair_t dir_slv [`GAUGE_COUNT];
    logic [11:0] mag_written;
    logic sync_irq_enable;
    logic sync_flag;
    logic flag_seen;
    logic [1:0] clk_sel;
    logic scan_start_bit;
    logic auto_mode_select;
    seq_state_t state;
    coil_idx_t ptr;
    logic ack;
    logic [5:0] en_meta;
    logic [5:0] en_sync;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire bus_req = WB_CYC_IN && WB_STB_IN;
    wire [5:0] idx = WB_ADR_IN[7:2];
    wire wr_fire = bus_req && ack && WB_WE_IN && WB_SEL_IN[0];
    wire rd_fire = bus_req && ack && !WB_WE_IN;
    wire [7:0] wd = WB_DAT_IN[7:0];
    wire is_mag = (idx >= `MAG_BASE_IDX) && (idx < `DIR_BASE_IDX);
    wire is_dir = (idx >= `DIR_BASE_IDX) && (idx < `SCAN_STATUS_CONTROL_IDX);
    wire is_scan_status_control = (idx == `SCAN_STATUS_CONTROL_IDX);
    wire [3:0] mag_sel = 4'(idx - `MAG_BASE_IDX);
    wire [2:0] dir_sel = 3'(idx - `DIR_BASE_IDX);
    wire scan_status_control_wr = wr_fire && is_scan_status_control;

    wire [7:0] scan_status_control_value = {sync_irq_enable, sync_flag,
                             1'b0,
                             clk_sel, 1'b0, scan_start_bit, auto_mode_select};
    wire [7:0] rd_mag = is_mag ? mag_slv[mag_sel] : 8'h00;
    wire [7:0] rd_dir = is_dir ? dir_read(dir_slv[dir_sel], dir_sel) : 8'h00;
    wire [7:0] rd_byte = is_scan_status_control ? scan_status_control_value : (rd_mag | rd_dir);

    // ----------------------------------------------------------------
    // step timing
    // ----------------------------------------------------------------
    wire step_start;
    wire dac_load;
    wire hold_close;
    wire step_end;
    wire running = (state == SEQ_SCAN);

    coil_step_timer #(
        .DIV_BASE(DIV_BASE),
        .DAC_WAIT(DAC_WAIT)
    ) u_timer (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .run_in(running),
        .clk_sel_in(clk_sel),
        .step_start_out(step_start),
        .dac_load_out(dac_load),
        .hold_close_out(hold_close),
        .step_end_out(step_end)
    );

    // ----------------------------------------------------------------
    // sequencing events
    // ----------------------------------------------------------------
    wire [2:0] cur_gauge = ptr[3:1];
    wire gauge_begin = step_start && !ptr[0];
    wire coil11_begin = step_start && (ptr == `SYNC_COIL_IDX);
    wire last_end = step_end && (ptr == `LAST_COIL_IDX);
    // a start request while one is still pending is dropped
    wire start_accept = scan_status_control_wr && wd[`SCAN_STATUS_CONTROL_START_BIT] && !scan_start_bit
                        && !auto_mode_select;
    wire copy_all = start_accept;
    wire flag_clear = scan_status_control_wr && wd[`SCAN_STATUS_CONTROL_FLAG_CLR_BIT] && flag_seen;
    wire next_sync_flag = coil11_begin || (sync_flag && !flag_clear);
    wire next_scan_start = start_accept || (scan_start_bit && !coil11_begin);
    wire continue_scan = auto_mode_select || scan_start_bit;

    logic [5:0] copy_gauge;
    logic [11:0] mag_wr_hit;
    logic [11:0] written_clr;

    always_comb begin
        for (int g = 0; g < `GAUGE_COUNT; g++) begin
            // manual copies every gauge start, automatic waits for both writes
            copy_gauge[g] = copy_all || (gauge_begin && (cur_gauge == 3'(g))
                            && (!auto_mode_select
                                || (mag_written[2 * g] && mag_written[2 * g + 1])));
        end
        for (int c = 0; c < `COIL_COUNT; c++) begin
            mag_wr_hit[c] = wr_fire && is_mag && (mag_sel == 4'(c));
            written_clr[c] = copy_gauge[c / 2];
        end
    end

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    // answer one cycle after the request; unmapped words read zero
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            ack <= 1'b0;
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h00000000;
        end else begin
            ack <= bus_req && !ack;
            WB_ACK_OUT <= bus_req && !ack;
            WB_DAT_OUT <= {24'h000000, rd_byte};
        end
    end

    // ----------------------------------------------------------------
    // magnitude buffers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        for (int c = 0; c < `COIL_COUNT; c++) begin
            if (RST_IN) begin
                mag_mst[c] <= `MAG_RESET;
                mag_slv[c] <= `MAG_RESET;
            end else begin
                if (mag_wr_hit[c]) begin
                    mag_mst[c] <= wd;
                end
                if (copy_gauge[c / 2]) begin
                    mag_slv[c] <= mag_mst[c];
                end
            end
        end
    end

    // a write landing on the copy edge stays pending for the next copy
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            mag_written <= 12'h000;
        end else begin
            mag_written <= (mag_written & ~written_clr) | mag_wr_hit;
        end
    end

    // ----------------------------------------------------------------
    // direction buffers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        for (int g = 0; g < `GAUGE_COUNT; g++) begin
            if (RST_IN) begin
                dir_mst[g] <= `DIR_RESET;
                dir_slv[g] <= `DIR_RESET;
            end else begin
                if (wr_fire && is_dir && (dir_sel == 3'(g))) begin
                    if (g < `MAJOR_COUNT) begin
                        dir_mst[g] <= wd[1:0];
                    end else begin
                        dir_mst[g] <= {wd[`DIR_MINOR_BIT], 1'b0};
                    end
                end
                if (copy_gauge[g]) begin
                    dir_slv[g] <= dir_mst[g];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // scan status and control
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            sync_irq_enable <= 1'b0;
            clk_sel <= 2'h0;
            auto_mode_select <= 1'b0;
        end else if (scan_status_control_wr) begin
            sync_irq_enable <= wd[`SCAN_STATUS_CONTROL_IRQ_EN_BIT];
            clk_sel <= {wd[`SCAN_STATUS_CONTROL_CLK_SEL_HI_BIT], wd[`SCAN_STATUS_CONTROL_CLK_SEL_LO_BIT]};
            auto_mode_select <= wd[`SCAN_STATUS_CONTROL_AUTO_BIT];
        end
    end

    // the clear only arms once software has read the flag as set
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            sync_flag <= 1'b0;
            flag_seen <= 1'b0;
            scan_start_bit <= 1'b0;
        end else begin
            sync_flag <= next_sync_flag;
            scan_start_bit <= next_scan_start;
            if (flag_clear) begin
                flag_seen <= 1'b0;
            end else if (rd_fire && is_scan_status_control && sync_flag) begin
                flag_seen <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // coil sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            state <= SEQ_IDLE;
            ptr <= 4'h0;
        end else begin
            case (state)
                SEQ_IDLE: begin
                    ptr <= 4'h0;
                    if (continue_scan) begin
                        state <= SEQ_SCAN;
                    end
                end
                SEQ_SCAN: begin
                    if (last_end) begin
                        ptr <= 4'h0;
                        if (!continue_scan) begin
                            state <= SEQ_IDLE;
                        end
                    end else if (step_end) begin
                        ptr <= ptr + 4'h1;
                    end
                end
                default: begin
                    state <= SEQ_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // analog side
    // ----------------------------------------------------------------
    // disabled gauges keep their slot but never close a hold switch
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            en_meta <= 6'h00;
            en_sync <= 6'h00;
            DRIVE_ON_OUT <= 6'h00;
        end else begin
            en_meta <= GAUGE_ENABLE_IN;
            en_sync <= en_meta;
            DRIVE_ON_OUT <= en_sync;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            HOLD_SWITCH_OUT <= 12'h000;
            COIL_SEL_OUT <= 4'h0;
            DAC_DATA_OUT <= 8'h00;
        end else begin
            if (step_start) begin
                HOLD_SWITCH_OUT <= 12'h000;
                COIL_SEL_OUT <= ptr;
            end else if (hold_close && en_sync[cur_gauge]) begin
                HOLD_SWITCH_OUT <= 12'h001 << ptr;
            end
            if (dac_load) begin
                DAC_DATA_OUT <= mag_slv[ptr];
            end
        end
    end

    // polarity follows the slave bit as the hold switch closes
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            COIL_DIR_OUT <= 12'h000;
        end else if (hold_close) begin
            COIL_DIR_OUT[ptr] <= dir_of_coil(dir_slv[cur_gauge], ptr);
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= sync_irq_enable && sync_flag;
        end
    end

endmodule // gauge_coil_scan_sequencer

// >>> testbench/gauge_scan_monitor.sv
`include "gauge_scan_map.svh"

module gauge_scan_monitor
    import gauge_scan_pkg::*;
#(
    parameter int DIV_BASE = 512
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [5:0] GAUGE_ENABLE_IN,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic WB_ACK_OUT,
    input wire logic [3:0] COIL_SEL_OUT,
    input wire logic [11:0] HOLD_SWITCH_OUT,
    input wire logic [11:0] COIL_DIR_OUT,
    input wire logic [5:0] DRIVE_ON_OUT
);
    // ------------------------------------------------
    // helper counters
    // ------------------------------------------------
    logic [15:0] gap;
    logic [2:0] warm;

    // gap saturates so a long idle spell cannot wrap into a short step
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN || COIL_SEL_OUT != $past(COIL_SEL_OUT)) begin
            gap <= 16'h0000;
        end else if (gap != 16'hFFFF) begin
            gap <= gap + 16'h0001;
        end
        if (RST_IN) begin
            warm <= 3'h0;
        end else if (warm != 3'h7) begin
            warm <= warm + 3'h1;
        end
    end

    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);

    ack_pulse_a: assert property ((WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
        else $error("ack is not a single pulse one cycle after the request");
    read_upper_a: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    clear_reads_a: assert property (WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN[7:2] == `SCAN_STATUS_CONTROL_IDX |-> !WB_DAT_OUT[5])
        else $error("flag clear bit read back as one");
    hold_onehot_a: assert property ($onehot0(HOLD_SWITCH_OUT))
        else $error("more than one hold switch closed");
    hold_coil_a: assert property (HOLD_SWITCH_OUT != 12'h000 |-> HOLD_SWITCH_OUT == (12'h001 << COIL_SEL_OUT))
        else $error("closed hold switch is not the current coil");
    // a disabled gauge keeps its switch open for the whole slot, so its low drive also ends the wait
    step_opens_a: assert property ($changed(COIL_SEL_OUT) |-> HOLD_SWITCH_OUT == 12'h000 ##[1:64]
        (HOLD_SWITCH_OUT != 12'h000 || !DRIVE_ON_OUT[COIL_SEL_OUT[3:1]]))
        else $error("coil step did not open then close its hold switch");
    coil_order_a: assert property ($changed(COIL_SEL_OUT) |-> COIL_SEL_OUT == $past(COIL_SEL_OUT) + 4'h1 || COIL_SEL_OUT == 4'h0)
        else $error("coil pointer skipped");
    coil_range_a: assert property (COIL_SEL_OUT <= `LAST_COIL_IDX)
        else $error("coil pointer beyond last coil");
    step_time_a: assert property ($changed(COIL_SEL_OUT) && COIL_SEL_OUT != 4'h0 |-> gap >= DIV_BASE - 1)
        else $error("coil step shorter than the base interval");
    minor_dir_a: assert property ((COIL_DIR_OUT & 12'h550) == 12'h000)
        else $error("minor coil one shows a polarity");
    drive_sync_a: assert property (warm == 3'h7 |-> DRIVE_ON_OUT == $past(GAUGE_ENABLE_IN, 3))
        else $error("gauge drive does not follow its enable");
endmodule // gauge_scan_monitor

bind gauge_coil_scan_sequencer gauge_scan_monitor #(.DIV_BASE(DIV_BASE)) mon (
    .CLK_SYS_IN, .RST_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .GAUGE_ENABLE_IN,
    .WB_DAT_OUT, .WB_ACK_OUT, .COIL_SEL_OUT, .HOLD_SWITCH_OUT, .COIL_DIR_OUT, .DRIVE_ON_OUT
);

// >>> testbench/gauge_coil_scan_sequencer_tb.sv
module gauge_coil_scan_sequencer_tb;
    import gauge_scan_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // short counts keep the run brief
    localparam int DIV = 32;
    localparam int DW = 4;
    logic clk, rst, cyc, stb, we, ack, irq;
    logic [7:0] adr, q, mag, dac;
    logic [3:0] sel, coil, last;
    logic [31:0] wdat, rdat;
    logic [5:0] gen, drv;
    logic [11:0] hold, cdir;
    logic [47:0] dv, prev;
    int errors, num_checks, cycles, laps, seed, t0;

    gauge_coil_scan_sequencer #(.DIV_BASE(DIV), .DAC_WAIT(DW)) uut (
        .CLK_SYS_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .GAUGE_ENABLE_IN(gen),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .DAC_DATA_OUT(dac), .COIL_SEL_OUT(coil),
        .HOLD_SWITCH_OUT(hold), .COIL_DIR_OUT(cdir), .DRIVE_ON_OUT(drv), .IRQ_OUT(irq)
    );

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        last <= coil;
        if (coil == 4'hB && last != 4'hB) begin
            laps <= laps + 1;
        end
        if (cycles == 40000) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, cycles, 0);
            errors++;
            final_report();
        end
    end

    function automatic logic [11:0] dirs(input logic [47:0] v);
        return {v[40], 1'b0, v[32], 1'b0, v[24], 1'b0, v[16], 1'b0, v[9:8], v[1:0]};
    endfunction

    task chk(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic cycle; the master never assumes the slave latency
    task wb(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, v};
        // a slave that never answers is caught by the cycle ceiling
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task wait_coil(input logic [3:0] n);
        @(negedge clk);
        while (coil !== n) @(negedge clk);
        repeat (DW + 3) @(negedge clk);
    endtask

    task final_report;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        seed = 32'h79096BF0;
        {rst, cyc, stb, we, adr, sel, wdat, gen} = {1'b1, 3'h0, 8'h00, 4'hF, 32'h0, 6'h3F};
        {errors, num_checks, cycles, laps, dv} = {32'h0, 32'h0, 32'h0, 32'h0, 48'h0};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        gen <= 6'($random(seed));
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, 8'h30 + 8'(4 * i), 8'h00);
            chk({4'h0, q}, 12'h000);
        end
        wb(1'b1, 8'h48, 8'h02);
        wait_coil(4'hA);
        wb(1'b1, 8'h48, 8'h20);
        wb(1'b1, 8'h48, 8'h80);
        repeat (2) @(negedge clk);
        chk({11'h0, irq}, 12'h001);
        wb(1'b0, 8'h48, 8'h00);
        chk({4'h0, q}, 12'h0C0);
        wb(1'b1, 8'h48, 8'h00);
        repeat (2) @(negedge clk);
        chk({11'h0, irq}, 12'h000);
        wb(1'b1, 8'h48, 8'h20);
        wb(1'b0, 8'h48, 8'h00);
        chk({4'h0, q}, 12'h000);
        for (int s = 0; s < 4; s++) begin
            prev = dv;
            dv = {16'($random(seed)), $random(seed)};
            gen <= 6'($random(seed));
            for (int i = 0; i < 6; i++) wb(1'b1, 8'h30 + 8'(4 * i), dv[8 * i +: 8]);
            wb(1'b0, 8'h30, 8'h00);
            chk({10'h0, q[1:0]}, {10'h0, prev[1:0]});
            laps = 0;
            wb(1'b1, 8'h48, 8'(s * 8 + 2));
            wait_coil(4'h3);
            t0 = cycles;
            wait_coil(4'h4);
            chk(12'(cycles - t0), 12'(DIV << s));
            // only one register of minor C is written; manual mode copies it all the same
            mag = 8'($random(seed));
            wb(1'b1, 8'h20, mag);
            wb(1'b1, 8'h48, 8'(s * 8 + 2));
            wait_coil(4'hA);
            wb(1'b0, 8'h48, 8'h00);
            chk({4'h0, q}, 12'(s * 8 + 64));
            wb(1'b1, 8'h48, 8'(s * 8 + 32));
            // a wrongly relaunched scan would pass coil 11 again in this span
            repeat (16 * (DIV << s)) @(negedge clk);
            chk(12'(laps), 12'h001);
            chk(cdir, dirs(dv));
            wb(1'b0, 8'h20, 8'h00);
            chk({4'h0, q}, {4'h0, mag});
            for (int i = 0; i < 6; i++) begin
                wb(1'b0, 8'h30 + 8'(4 * i), 8'h00);
                chk({4'h0, q} & (i < 2 ? 12'h003 : 12'h001), {4'h0, dv[8 * i +: 8]} & (i < 2 ? 12'h003 : 12'h001));
            end
        end
        mag = 8'($random(seed)) | 8'h01;
        wb(1'b1, 8'h00, mag);
        laps = 0;
        wb(1'b1, 8'h48, 8'h01);
        wait_coil(4'h1);
        wait_coil(4'h0);
        chk({4'h0, dac}, 12'h000);
        wb(1'b1, 8'h04, 8'h00);
        wait_coil(4'h1);
        wait_coil(4'h0);
        chk({4'h0, dac}, {4'h0, mag});
        chk(12'(laps), 12'h002);
        final_report();
    end
endmodule // gauge_coil_scan_sequencer_tb
